/* File: arsf_pkg.sv */
// Purpose: Shared constants for the converter result and status flag block
// Assumes: 32-bit AXI4-Lite register bus, one word per register
// Notes: Offsets are byte addresses
`default_nettype none
package arsf_pkg;
  localparam int ARSF_NCH = 8; // Channel count
  localparam int ARSF_RES_W = 10; // Result width
  localparam int ARSF_IDX_W = 3; // Channel index width
  localparam logic [11:0] ARSF_OFS_CTRL = 12'h000; // Control: start pulse
  localparam logic [11:0] ARSF_OFS_MODE = 12'h004; // Mode: sleep select
  localparam logic [11:0] ARSF_OFS_CHEN = 12'h010; // Channel enable
  localparam logic [11:0] ARSF_OFS_STAT = 12'h01C; // Status
  localparam logic [11:0] ARSF_OFS_LAST = 12'h020; // Last result
  localparam logic [11:0] ARSF_OFS_IMASK = 12'h028; // Interrupt mask
  localparam logic [11:0] ARSF_OFS_ISTAT = 12'h02C; // Sticky events, write one to clear
  localparam logic [11:0] ARSF_OFS_CH0 = 12'h030; // Channel 0 result, 4 bytes apart
  localparam int ARSF_DONE_LSB = 0; // Done flags in status
  localparam int ARSF_OVR_LSB = 8; // Channel overrun flags in status
  localparam int ARSF_DATA_READY_FLAG_BIT = 16; // Data ready in status
  localparam int ARSF_GOVR_BIT = 17; // Global overrun in status
  localparam int ARSF_SLEEP_BIT = 18; // Asleep indication in status
  localparam int ARSF_LAST_CH_LSB = 12; // Channel number in last result
  localparam logic [1:0] ARSF_RESP_OK = 2'h0; // OKAY
  localparam logic [1:0] ARSF_RESP_ERR = 2'h2; // SLVERR
  localparam int ARSF_NEV = 3; // Events: result stored, global overrun, channel overrun
  typedef enum logic [1:0] {
    ARSF_AWAKE = 2'h1,
    ARSF_ASLEEP = 2'h2
  } arsf_pwr_type;
endpackage
`default_nettype wire

/* File: arsf_status.sv */
// Purpose: Per-channel done and overrun flags, global ready and overrun flags
// Assumes: Conversion core gives one-cycle end pulses with channel and data
// Notes: All flag updates let a same-cycle set win over a clear
`default_nettype none
module arsf_status
  import arsf_pkg::*;
#(
  parameter int NCH = ARSF_NCH,
  parameter int RES_W = ARSF_RES_W
) (
  input wire logic clk_i,
  input wire logic srst_i,
  // AXI4-Lite slave
  input wire logic [11:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  input wire logic [11:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i,
  // Conversion core
  input wire logic eoc_i,
  input wire logic [ARSF_IDX_W-1:0] eoc_ch_i,
  input wire logic [RES_W-1:0] eoc_data_i,
  input wire logic core_busy_i,
  output logic conv_start_o,
  output logic [NCH-1:0] ch_enable_o,
  output logic sleep_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [NCH-1:0] done; // Per-channel conversion done
  logic [NCH-1:0] ch_ovr; // Per-channel overrun
  logic [NCH-1:0] conv_live; // Conversion running while enabled
  logic data_ready_flag; // Global data ready
  logic govr; // Global overrun
  logic [RES_W-1:0] ch_res [NCH]; // Channel results
  logic [RES_W-1:0] last_res; // Last result
  logic [ARSF_IDX_W-1:0] last_ch; // Channel of last result
  logic sleep_sel; // Sleep requested
  arsf_pwr_type pwr; // Power state
  logic [ARSF_NEV-1:0] istat; // Sticky events
  logic [ARSF_NEV-1:0] imask; // Event mask

  // Write channel holding
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  ////////////////////////////////////////////////////////////////////////////
  // Address helpers
  function automatic logic is_ch_addr(input logic [11:0] a);
    return (a >= ARSF_OFS_CH0) && (a < ARSF_OFS_CH0 + 12'(4 * NCH)) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [ARSF_IDX_W-1:0] ch_of(input logic [11:0] a);
    logic [11:0] d;
    d = a - ARSF_OFS_CH0;
    return d[ARSF_IDX_W+1:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Read-side strobes: a read takes effect in its accept cycle
  logic rd_take;
  logic rd_stat;
  logic rd_last;
  logic rd_chan;
  logic [ARSF_IDX_W-1:0] rd_ch;
  assign rd_take = s_arvalid_i && s_arready_o;
  assign rd_stat = rd_take && (s_araddr_i == ARSF_OFS_STAT);
  assign rd_last = rd_take && (s_araddr_i == ARSF_OFS_LAST);
  assign rd_chan = rd_take && is_ch_addr(s_araddr_i);
  assign rd_ch = ch_of(s_araddr_i);

  // Write strobe once both address and data are held
  logic wr_go;
  logic wr_b0;
  assign wr_go = aw_held && w_held && !s_bvalid_o;
  assign wr_b0 = w_strb[0];

  // Channel disable this cycle, seen by live tracking and the enable register
  logic [NCH-1:0] next_enable;
  always_comb begin
    next_enable = ch_enable_o;
    if (wr_go && aw_addr == ARSF_OFS_CHEN && wr_b0) begin
      next_enable = w_data[NCH-1:0];
    end
  end

  // A stored result needs an end on a channel still live
  logic eoc_ok;
  assign eoc_ok = eoc_i && conv_live[eoc_ch_i] && ch_enable_o[eoc_ch_i];

  ////////////////////////////////////////////////////////////////////////////
  // Live tracking: a disable during a conversion kills that channel's result
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      conv_live <= '0;
    end else begin
      conv_live <= next_enable & ch_enable_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel done and overrun; set beats clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      done <= '0;
      ch_ovr <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        logic hit;
        hit = eoc_ok && (eoc_ch_i == ARSF_IDX_W'(i));
        if (hit) begin
          done[i] <= 1'b1;
        end else if (rd_last || (rd_chan && rd_ch == ARSF_IDX_W'(i))) begin
          done[i] <= 1'b0;
        end
        if (hit && done[i]) begin
          ch_ovr[i] <= 1'b1;
        end else if (rd_stat) begin
          ch_ovr[i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Global flags; an accepted end sets, then reads clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      data_ready_flag <= 1'b0;
      govr <= 1'b0;
    end else begin
      if (eoc_ok) begin
        data_ready_flag <= 1'b1;
      end else if (rd_last) begin
        data_ready_flag <= 1'b0;
      end
      if (eoc_ok && data_ready_flag) begin
        govr <= 1'b1;
      end else if (rd_stat) begin
        govr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result storage; a new result overwrites the old one
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < NCH; i++) begin
        ch_res[i] <= '0;
      end
      last_res <= '0;
      last_ch <= '0;
    end else if (eoc_ok) begin
      ch_res[eoc_ch_i] <= eoc_data_i;
      last_res <= eoc_data_i;
      last_ch <= eoc_ch_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep: entry waits for a conversion end, so idle selection is deferred
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pwr <= ARSF_AWAKE;
    end else begin
      case (pwr)
        ARSF_AWAKE: begin
          if (sleep_sel && eoc_i && !core_busy_i) begin
            pwr <= ARSF_ASLEEP;
          end
        end
        ARSF_ASLEEP: begin
          if (!sleep_sel || conv_start_o) begin
            pwr <= ARSF_AWAKE; // Start wakes the core
          end
        end
        default: begin
          pwr <= ARSF_AWAKE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sleep_o <= 1'b0;
    end else begin
      sleep_o <= (pwr == ARSF_ASLEEP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write side: address and data taken in either order
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_bvalid_o <= 1'b0;
      s_bresp_o <= ARSF_RESP_OK;
    end else begin
      if (s_awvalid_i && s_awready_o) begin
        aw_held <= 1'b1;
        aw_addr <= s_awaddr_i;
      end
      if (s_wvalid_i && s_wready_o) begin
        w_held <= 1'b1;
        w_data <= s_wdata_i;
        w_strb <= s_wstrb_i;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_bvalid_o <= 1'b1;
        case (aw_addr)
          ARSF_OFS_CTRL, ARSF_OFS_MODE, ARSF_OFS_CHEN,
          ARSF_OFS_IMASK, ARSF_OFS_ISTAT: s_bresp_o <= ARSF_RESP_OK;
          default: s_bresp_o <= ARSF_RESP_ERR;
        endcase
      end else if (s_bvalid_o && s_bready_i) begin
        s_bvalid_o <= 1'b0;
      end
    end
  end

  always_comb begin
    s_awready_o = !aw_held && !s_bvalid_o;
    s_wready_o = !w_held && !s_bvalid_o;
  end

  // Control registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ch_enable_o <= '0;
      sleep_sel <= 1'b0;
      imask <= '0;
      conv_start_o <= 1'b0;
    end else begin
      ch_enable_o <= next_enable;
      conv_start_o <= wr_go && aw_addr == ARSF_OFS_CTRL && wr_b0 && w_data[0];
      if (wr_go && wr_b0 && aw_addr == ARSF_OFS_MODE) begin
        sleep_sel <= w_data[0];
      end
      if (wr_go && wr_b0 && aw_addr == ARSF_OFS_IMASK) begin
        imask <= w_data[ARSF_NEV-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt events: sticky, set wins over write-one-to-clear
  logic [ARSF_NEV-1:0] ev;
  assign ev = {eoc_ok && (done[eoc_ch_i]), eoc_ok && data_ready_flag, eoc_ok};
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      istat <= '0;
      irq_o <= 1'b0;
    end else begin
      logic [ARSF_NEV-1:0] clr;
      clr = (wr_go && wr_b0 && aw_addr == ARSF_OFS_ISTAT) ? w_data[ARSF_NEV-1:0] : '0;
      istat <= (istat & ~clr) | ev;
      irq_o <= |(((istat & ~clr) | ev) & imask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read side: data registered one cycle after address accept
  logic [31:0] rd_word;
  logic rd_hit;
  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    if (is_ch_addr(s_araddr_i)) begin
      rd_word[RES_W-1:0] = ch_res[rd_ch];
    end else begin
      case (s_araddr_i)
        ARSF_OFS_MODE: rd_word[0] = sleep_sel;
        ARSF_OFS_CHEN: rd_word[NCH-1:0] = ch_enable_o;
        ARSF_OFS_STAT: begin
          rd_word[ARSF_DONE_LSB +: NCH] = done;
          rd_word[ARSF_OVR_LSB +: NCH] = ch_ovr;
          rd_word[ARSF_DATA_READY_FLAG_BIT] = data_ready_flag;
          rd_word[ARSF_GOVR_BIT] = govr;
          rd_word[ARSF_SLEEP_BIT] = (pwr == ARSF_ASLEEP);
        end
        ARSF_OFS_LAST: begin
          rd_word[RES_W-1:0] = last_res;
          rd_word[ARSF_LAST_CH_LSB +: ARSF_IDX_W] = last_ch;
        end
        ARSF_OFS_IMASK: rd_word[ARSF_NEV-1:0] = imask;
        ARSF_OFS_ISTAT: rd_word[ARSF_NEV-1:0] = istat;
        ARSF_OFS_CTRL: rd_word = '0;
        default: rd_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_rvalid_o <= 1'b0;
      s_rdata_o <= '0;
      s_rresp_o <= ARSF_RESP_OK;
    end else if (rd_take) begin
      s_rvalid_o <= 1'b1;
      s_rdata_o <= rd_word;
      s_rresp_o <= rd_hit ? ARSF_RESP_OK : ARSF_RESP_ERR;
    end else if (s_rvalid_o && s_rready_i) begin
      s_rvalid_o <= 1'b0;
    end
  end

  always_comb begin
    s_arready_o = !s_rvalid_o;
  end

endmodule
`default_nettype wire

/* File: arsf_checker.sv */
// Purpose: Port timing checks for the result status flag block
// Assumes: One clock, synchronous active-high reset
// Notes: Flag values are judged by the bench through register reads
`default_nettype none
module arsf_checker
  import arsf_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic s_awvalid_i,
  input wire logic s_awready_o,
  input wire logic s_wvalid_i,
  input wire logic s_wready_o,
  input wire logic s_bvalid_o,
  input wire logic [11:0] s_araddr_i,
  input wire logic s_arvalid_i,
  input wire logic s_arready_o,
  input wire logic [31:0] s_rdata_o,
  input wire logic [1:0] s_rresp_o,
  input wire logic s_rvalid_o,
  input wire logic s_rready_i,
  input wire logic eoc_i,
  input wire logic core_busy_i,
  input wire logic conv_start_o,
  input wire logic [ARSF_NCH-1:0] ch_enable_o,
  input wire logic sleep_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  a_rd_answer: assert property (s_arvalid_i && s_arready_o |=> s_rvalid_o)
    else $error("read answer late");
  a_r_drop: assert property (s_rvalid_o && s_rready_i |=> !s_rvalid_o)
    else $error("read answer repeated");
  a_ar_blocked: assert property (s_rvalid_o |-> !s_arready_o)
    else $error("read taken while answer pending");
  a_wr_answer: assert property (s_awvalid_i && s_awready_o && s_wvalid_i && s_wready_o
    |-> ##[1:3] s_bvalid_o) else $error("write answer late");
  a_rd_err: assert property (s_arvalid_i && s_arready_o && s_araddr_i == 12'hFFC
    |=> s_rresp_o == ARSF_RESP_ERR && s_rdata_o == 32'h0) else $error("unmapped read");
  a_start_pulse: assert property (conv_start_o |=> !conv_start_o)
    else $error("start longer than one cycle");
  a_en_cause: assert property ($changed(ch_enable_o) |-> $past(s_wvalid_i)
    || $past(s_wvalid_i, 2)) else $error("enables moved without a write");
  a_sleep_entry: assert property ($rose(sleep_o) |-> $past(eoc_i, 2)
    && !$past(core_busy_i, 2)) else $error("sleep without a finished conversion");
endmodule
bind arsf_status arsf_checker i_chk (.*);
`default_nettype wire

/* File: arsf_core_model.sv */
// Purpose: Conversion core stand-in
// Assumes: Bench raises go_i one cycle before the end pulse
// Notes: Result of channel c is 0x100 plus c; lines scramble when idle
`default_nettype none
module arsf_core_model
  import arsf_pkg::*;
(
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [2:0] ch_i,
  input wire logic start_i,
  output logic eoc_o = 1'b0,
  output logic [2:0] ch_o = 3'h0,
  output logic [ARSF_RES_W-1:0] dat_o = 10'h0,
  output logic busy_o = 1'b0
);
  // End pulse; busy falls with it so an idle end can trigger sleep
  always_ff @(posedge clk_i) begin
    eoc_o <= go_i;
    ch_o <= go_i ? ch_i : ~ch_o;
    dat_o <= go_i ? {7'h00, ch_i} + 10'h100 : ~dat_o;
    busy_o <= start_i ? 1'b1 : (go_i ? 1'b0 : busy_o);
  end
endmodule
`default_nettype wire

/* File: testbench.sv */
// Purpose: Self-checking bench for the result status flag block
// Assumes: Write ready and address ready rise together
// Notes: Collisions are made by firing the core with the request
`default_nettype none
module testbench;
  import arsf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, srst_i = 1, awv = 0, wv = 0, arv = 0, go = 0;
  logic [11:0] aw = 0, ar = 0;
  logic [31:0] wd = 0, d, rdt;
  logic [2:0] gch = 0, ech;
  logic [1:0] rsp, br, rr;
  logic awr, wrr, bv, arr, rv, eoc, busy, st, slp, irq;
  logic [9:0] edat;
  logic [7:0] en;
  int fails = 0, n_tests = 0;
  arsf_status i_dut (.clk_i(clk_i), .srst_i(srst_i), .s_awaddr_i(aw), .s_awvalid_i(awv),
    .s_awready_o(awr), .s_wdata_i(wd), .s_wstrb_i(4'hF), .s_wvalid_i(wv), .s_wready_o(wrr),
    .s_bresp_o(br), .s_bvalid_o(bv), .s_bready_i(1'b1), .s_araddr_i(ar), .s_arvalid_i(arv),
    .s_arready_o(arr), .s_rdata_o(rdt), .s_rresp_o(rr), .s_rvalid_o(rv), .s_rready_i(1'b1),
    .eoc_i(eoc), .eoc_ch_i(ech), .eoc_data_i(edat), .core_busy_i(busy),
    .conv_start_o(st), .ch_enable_o(en), .sleep_o(slp), .irq_o(irq));
  arsf_core_model i_core (.clk_i(clk_i), .go_i(go), .ch_i(gch), .start_i(st), .eoc_o(eoc),
    .ch_o(ech), .dat_o(edat), .busy_o(busy));
  initial forever #5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Read; with f set the core ends channel c at the edge that takes it
  task automatic rd(input logic [11:0] a, input logic f = 0, input logic [2:0] c = 0);
    go <= f;
    gch <= c;
    @(posedge clk_i);
    go <= 0;
    ar <= a;
    arv <= 1;
    do @(posedge clk_i); while (!arr);
    arv <= 0;
    do @(posedge clk_i); while (!rv);
    d = rdt;
    rsp = rr;
  endtask
  // Write; with f set the end lands on the write's effect edge
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic f = 0,
      input logic [2:0] c = 0);
    logic pa; // Address still offered
    logic pw; // Data still offered
    pa = 1;
    pw = 1;
    go <= f;
    gch <= c;
    aw <= a;
    wd <= v;
    awv <= 1;
    wv <= 1;
    // Each channel is released at the edge that takes it
    do begin
      @(posedge clk_i);
      go <= 0;
      if (pa && awr) begin
        pa = 0;
        awv <= 0;
      end
      if (pw && wrr) begin
        pw = 0;
        wv <= 0;
      end
    end while (pa || pw);
    do @(posedge clk_i); while (!bv);
    rsp = br;
    @(posedge clk_i);
  endtask
  // Lone end of conversion, carried by an unmapped read
  task automatic ev(input logic [2:0] c);
    rd(12'hFFC, 1, c);
    chk(32'(rsp), 32'(ARSF_RESP_ERR));
  endtask
  task automatic st_is(input logic [31:0] e);
    rd(ARSF_OFS_STAT);
    chk(d, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_ready;
    ev(1);
    rd(ARSF_OFS_CH0 + 12'h004);
    chk(d, 32'h101);
    st_is(32'h10000);
    rd(ARSF_OFS_LAST);
    chk(d, 32'h1101);
    st_is(32'h0);
  endtask
  task automatic t_collide;
    ev(2);
    ev(5);
    rd(ARSF_OFS_STAT);
    rd(ARSF_OFS_CH0, 1, 2);
    st_is(32'h30424);
  endtask
  // Status reads meeting ends: clear when nothing new, set on overrun
  task automatic t_status;
    ev(2);
    rd(ARSF_OFS_CH0 + 12'h008);
    rd(ARSF_OFS_LAST);
    chk(d, 32'h2102);
    rd(ARSF_OFS_STAT, 1, 2);
    st_is(32'h10004);
    rd(ARSF_OFS_STAT, 1, 3);
    st_is(32'h3000C);
    rd(ARSF_OFS_LAST);
  endtask
  task automatic t_disable;
    wr(ARSF_OFS_CHEN, 32'hF7);
    ev(1);
    rd(ARSF_OFS_LAST, 1, 3);
    st_is(32'h0);
    wr(ARSF_OFS_CHEN, 32'hF3, 1, 6);
    chk(32'(en), 32'hF3);
    st_is(32'h10040);
    wr(ARSF_OFS_CHEN, 32'hE3, 1, 6);
    st_is(32'h34040);
    rd(ARSF_OFS_LAST);
    wr(ARSF_OFS_STAT, 32'h0);
    chk(32'(rsp), 32'(ARSF_RESP_ERR));
  endtask
  task automatic t_irq;
    wr(ARSF_OFS_ISTAT, 32'h7);
    wr(ARSF_OFS_IMASK, 32'h1);
    chk(32'(irq), 32'h0);
    ev(1);
    chk(32'(irq), 32'h1);
    wr(ARSF_OFS_IMASK, 32'h0);
    chk(32'(irq), 32'h0);
    wr(ARSF_OFS_IMASK, 32'h1);
    wr(ARSF_OFS_ISTAT, 32'h1);
    chk(32'(irq), 32'h0);
    rd(ARSF_OFS_LAST);
  endtask
  task automatic t_sleep;
    wr(ARSF_OFS_MODE, 32'h1);
    chk(32'(slp), 32'h0);
    wr(ARSF_OFS_CTRL, 32'h1);
    ev(0);
    repeat (2) @(posedge clk_i);
    chk(32'(slp), 32'h1);
    wr(ARSF_OFS_MODE, 32'h0);
    // Wake lands one edge after the select, the pin one edge later
    @(posedge clk_i);
    chk(32'(slp), 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    srst_i <= 0;
    wr(ARSF_OFS_CHEN, 32'hFF);
    t_ready;
    t_collide;
    t_status;
    t_disable;
    t_irq;
    t_sleep;
    give_verdict;
  end
  // Hang guard: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    give_verdict;
  end
endmodule
`default_nettype wire
